// ==== hcl_config_loader.sv ====
// hub configuration loader: straps, eeprom reader, option decode
//
// Summary of operation
// [RQ1] Config source comes from two strap pins sampled at reset release.
// [RQ2] Vendor and product codes are 16 bits, loaded or built-in defaults.
// [RQ3] Release code is 16-bit BCD, loaded or built-in default.
// [RQ4] Default option: power mode follows local power pin; else loaded bit.
// [RQ5] Full-speed-only option suppresses high-speed attach.
// [RQ6] End-of-packet option matters only while running at full speed.
// [RQ7] Current sensing ganged or none; defaults follow local power pin.
// [RQ8] Strap configuration: any fixed port makes the hub report compound.
// [RQ9] Default option: two fixed-port straps mark ports permanently attached.
// [RQ10] Self-powered: ports in self-powered disable field stay disabled.
// [RQ11] Bus-powered: ports in bus-powered disable field stay disabled.
// [RQ12] Configuring party disables ports downward starting at port 2.
// [RQ13] Dynamic switching: power pin change drops ports, detaches, reattaches.
// [RQ14] Dynamic switching: local power present always means self-powered.
// [RQ15] Over-current reported only after persisting the programmed 2ms steps.
// [RQ16] Max-power and hub current fields are in 2mA units.
// [RQ17] Power-on time in 2ms units is reported to host software.
// [RQ18] Port power switch polarity is set by strap only.
// [RQ19] No upstream pull-up without bus power; removed within 10 seconds.
// [RQ20] Eeprom source: read eeprom first, attach upstream afterwards.
// [RQ21] Sole 100 kbit/s I2C master; drives clock, START and STOP.
// [RQ22] Eeprom slave address 1010000, 7-bit only.
// [RQ23] Eeprom pins released while reset is held low.
// [RQ24] Config byte 6: bit 7 power mode, bit 5 full-speed-only.
// [RQ25] Dynamic switching ignores configured power-mode bit, uses the pin.
// [RQ26] Read eeprom bytes 0x00 to 0x0F, then hold them until reset.
`timescale 1ns/10ps
`default_nettype none

module hcl_config_loader
  import hcl_pkg::*;
#(
  parameter int P_OC_STEP_CYC = OC_STEP_CYC,
  parameter int P_I2C_QTR_CYC = I2C_QTR_CYC,
  // arbitrary built-in identity values
  parameter logic [15:0] P_DEFAULT_VENDOR = 16'hA5C3,
  parameter logic [15:0] P_DEFAULT_PRODUCT = 16'h1E02
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  // strap and sense pins
  input wire logic i_config_source_strap_hi,
  input wire logic i_config_source_strap_lo,
  input wire logic i_local_power_detect,
  input wire logic [1:0] i_fixed_port_straps,
  input wire logic i_power_polarity_strap,
  input wire logic i_upstream_bus_power_sense,
  input wire logic i_overcurrent,
  // hub core status
  input wire logic i_full_speed_active,
  // smbus slave result
  input wire hcl_cfg_s i_smbus_cfg,
  input wire logic i_smbus_cfg_valid,
  // eeprom pins
  input wire logic i_scl,
  input wire logic i_sda,
  output hcl_i2c_s o_i2c,
  // loaded configuration and status
  output hcl_cfg_s o_cfg,
  output logic o_config_done,
  output logic [1:0] o_config_source,
  output logic o_eeprom_error,
  // applied options
  output logic o_self_powered,
  output logic o_full_speed_only,
  output logic o_eop_at_eof1,
  output logic o_current_sense_ganged,
  output logic o_compound_device,
  output logic [1:0] o_fixed_ports,
  output logic [1:0] o_port_enable,
  output logic [7:0] o_max_power_2ma,
  output logic [7:0] o_hub_current_2ma,
  output logic [7:0] o_power_on_time_2ms,
  // power and attach
  output logic o_overcurrent_report,
  output logic o_port_power_switch_out,
  output logic o_upstream_pullup_en
);

  // ==========================================================================
  // pin synchronisers
  logic [9:0] pin_meta;
  logic [9:0] pin_sync;
  logic [1:0] src_pins;
  logic lpd_s;
  logic vbus_s;
  logic oc_s;
  logic scl_s;
  logic sda_s;
  logic pol_s;
  logic [1:0] fixed_s;

  always_ff @(posedge i_sys_clk) begin
    pin_meta <= {i_config_source_strap_hi, i_config_source_strap_lo,
                 i_local_power_detect, i_upstream_bus_power_sense,
                 i_overcurrent, i_scl, i_sda, i_power_polarity_strap,
                 i_fixed_port_straps};
    pin_sync <= pin_meta;
  end

  assign src_pins = pin_sync[9:8];
  assign lpd_s = pin_sync[7];
  assign vbus_s = pin_sync[6];
  assign oc_s = pin_sync[5];
  assign scl_s = pin_sync[4];
  assign sda_s = pin_sync[3];
  assign pol_s = pin_sync[2];
  assign fixed_s = pin_sync[1:0];

  // ==========================================================================
  // built-in defaults
  function automatic hcl_cfg_s default_cfg(input logic [1:0] fixed);
    hcl_cfg_s c;
    c.vendor_code = P_DEFAULT_VENDOR; // RQ2
    c.product_code = P_DEFAULT_PRODUCT; // RQ2
    c.release_code = DEF_RELEASE; // RQ3
    c.cfg_byte1 = DEF_CFG1_SELF;
    c.cfg_byte2 = DEF_CFG2;
    c.fixed_ports = {5'h00, fixed, 1'b0}; // RQ9
    c.port_off_self = DEF_PORT_OFF;
    c.port_off_bus = DEF_PORT_OFF;
    c.max_power_self = DEF_MAXP_SELF;
    c.max_power_bus = DEF_MAXP_BUS;
    c.hub_current_self = DEF_HC_SELF;
    c.hub_current_bus = DEF_HC_BUS;
    c.power_on_time = DEF_PON;
    return c;
  endfunction

  // ==========================================================================
  // sequencer and i2c bit engine
  hcl_state_e state;
  logic [1:0] src;
  logic [1:0] fixed;
  logic pol;
  logic [7:0] qcnt;
  logic [1:0] phase;
  logic [3:0] bitn;
  logic [7:0] shreg;
  logic [3:0] byte_idx;
  logic ee_err;
  logic [7:0] ee_mem [16];
  logic ee_busy;
  logic scl_low;
  logic sda_low;
  logic stall;
  logic qtick;
  logic slot_end;
  logic sample;

  assign ee_busy = (state != ST_STRAP) && (state != ST_SMBUS_WAIT) &&
                   (state != ST_READY);
  assign stall = (phase == 2'h1) && !scl_low && !scl_s;
  assign qtick = ee_busy && !stall && (qcnt == 8'(P_I2C_QTR_CYC - 1));
  assign slot_end = qtick && (phase == 2'h3);
  assign sample = qtick && (phase == 2'h2);

  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst || !ee_busy) begin
      qcnt <= 8'h00;
    end else if (qtick) begin
      qcnt <= 8'h00; // RQ21
    end else if (!stall) begin
      qcnt <= qcnt + 8'h01;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      state <= ST_STRAP;
      src <= SRC_DEFAULT;
      fixed <= 2'h0;
      pol <= 1'b0;
      phase <= 2'h0;
      bitn <= 4'h0;
      shreg <= 8'h00;
      byte_idx <= EE_FIRST_OFS;
      ee_err <= 1'b0;
    end else begin
      if (qtick) begin
        phase <= phase + 2'h1;
      end
      unique case (state)
        ST_STRAP: begin
          src <= src_pins; // RQ1
          fixed <= fixed_s;
          pol <= pol_s; // RQ18
          if (src_pins == SRC_DEFAULT) begin
            state <= ST_READY;
          end else if (src_pins == SRC_SMBUS) begin
            state <= ST_SMBUS_WAIT;
          end else begin
            state <= ST_EE_START; // RQ20
          end
        end
        ST_SMBUS_WAIT: begin
          if (i_smbus_cfg_valid) begin
            state <= ST_READY;
          end
        end
        ST_EE_START, ST_EE_RESTART: begin
          if (slot_end) begin
            shreg <= {EE_SLAVE_ADDR, state == ST_EE_RESTART}; // RQ22
            bitn <= 4'h0;
            state <= (state == ST_EE_START) ? ST_EE_DEVW : ST_EE_DEVR;
          end
        end
        ST_EE_DEVW, ST_EE_OFS, ST_EE_DEVR: begin
          if (sample && bitn == BITN_ACK && sda_s) begin
            ee_err <= 1'b1;
          end
          if (slot_end) begin
            if (bitn != BITN_ACK) begin
              shreg <= {shreg[6:0], 1'b0};
              bitn <= bitn + 4'h1;
            end else begin
              bitn <= 4'h0;
              if (ee_err) begin
                state <= ST_EE_STOP;
              end else if (state == ST_EE_DEVW) begin
                shreg <= {4'h0, EE_FIRST_OFS}; // RQ26
                state <= ST_EE_OFS;
              end else if (state == ST_EE_OFS) begin
                state <= ST_EE_RESTART;
              end else begin
                state <= ST_EE_READ;
              end
            end
          end
        end
        ST_EE_READ: begin
          if (sample && bitn != BITN_ACK) begin
            shreg <= {shreg[6:0], sda_s};
          end
          if (slot_end) begin
            if (bitn != BITN_ACK) begin
              bitn <= bitn + 4'h1;
            end else begin
              bitn <= 4'h0;
              ee_mem[byte_idx] <= shreg; // RQ26
              if (byte_idx == EE_LAST_OFS) begin
                state <= ST_EE_STOP;
              end else begin
                byte_idx <= byte_idx + 4'h1;
              end
            end
          end
        end
        ST_EE_STOP: begin
          if (slot_end) begin
            if (ee_err) begin
              src <= SRC_DEFAULT;
            end
            state <= ST_READY;
          end
        end
        ST_READY: begin
        end
      endcase
    end
  end

  // open-drain pin drive: only low is ever driven
  always_comb begin
    scl_low = 1'b0;
    sda_low = 1'b0;
    unique case (state)
      ST_EE_START, ST_EE_RESTART: begin
        scl_low = (phase == 2'h0) || (phase == 2'h3); // RQ21
        sda_low = phase[1];
      end
      ST_EE_DEVW, ST_EE_OFS, ST_EE_DEVR: begin
        scl_low = (phase == 2'h0) || (phase == 2'h3);
        sda_low = (bitn != BITN_ACK) && !shreg[7];
      end
      ST_EE_READ: begin
        scl_low = (phase == 2'h0) || (phase == 2'h3);
        sda_low = (bitn == BITN_ACK) && (byte_idx != EE_LAST_OFS);
      end
      ST_EE_STOP: begin
        scl_low = (phase == 2'h0); // RQ21
        sda_low = !phase[1];
      end
      ST_STRAP, ST_SMBUS_WAIT, ST_READY: begin
      end
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      o_i2c <= '0; // RQ23
    end else begin
      o_i2c <= '{scl_out: 1'b0, scl_oe: scl_low,
                 sda_out: 1'b0, sda_oe: sda_low};
    end
  end

  // ==========================================================================
  // configuration store, held until reset
  hcl_cfg_s cfg;
  hcl_cfg_s ee_cfg;

  always_comb begin
    ee_cfg.vendor_code = {ee_mem[OFS_VENDOR_HI], ee_mem[OFS_VENDOR_LO]};
    ee_cfg.product_code = {ee_mem[OFS_PRODUCT_HI], ee_mem[OFS_PRODUCT_LO]};
    ee_cfg.release_code = {ee_mem[OFS_RELEASE_HI], ee_mem[OFS_RELEASE_LO]};
    ee_cfg.cfg_byte1 = ee_mem[OFS_CFG1]; // RQ24
    ee_cfg.cfg_byte2 = ee_mem[OFS_CFG2];
    ee_cfg.fixed_ports = ee_mem[OFS_FIXED];
    ee_cfg.port_off_self = ee_mem[OFS_OFF_SELF];
    ee_cfg.port_off_bus = ee_mem[OFS_OFF_BUS];
    ee_cfg.max_power_self = ee_mem[OFS_MAXP_SELF];
    ee_cfg.max_power_bus = ee_mem[OFS_MAXP_BUS];
    ee_cfg.hub_current_self = ee_mem[OFS_HC_SELF];
    ee_cfg.hub_current_bus = ee_mem[OFS_HC_BUS];
    ee_cfg.power_on_time = ee_mem[OFS_PON];
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      cfg <= '0;
    end else if (state == ST_STRAP && src_pins == SRC_DEFAULT) begin
      cfg <= default_cfg(fixed_s); // RQ2
    end else if (state == ST_SMBUS_WAIT && i_smbus_cfg_valid) begin
      cfg <= i_smbus_cfg;
    end else if (state == ST_EE_STOP && slot_end) begin
      cfg <= ee_err ? default_cfg(fixed) : ee_cfg; // RQ26
    end
  end

  // ==========================================================================
  // option decode, dynamic power and attach
  logic ready;
  logic is_dflt;
  logic dyn;
  logic next_self;
  logic lpd_prev;
  logic [10:0] rc_cnt;
  logic attach;
  logic [7:0] port_off;

  assign is_dflt = (src == SRC_DEFAULT);
  assign dyn = cfg.cfg_byte2[CFG2_DYN_POWER_BIT];
  assign next_self = (is_dflt || dyn) ? lpd_s : // RQ4 RQ14 RQ25
                     cfg.cfg_byte1[CFG1_POWER_MODE_BIT]; // RQ24
  assign attach = ready && (rc_cnt == 11'h000); // RQ20
  assign port_off = next_self ? cfg.port_off_self : // RQ10
                    cfg.port_off_bus; // RQ11

  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      ready <= 1'b0;
      lpd_prev <= 1'b0;
      rc_cnt <= 11'h000;
    end else begin
      ready <= (state == ST_READY);
      lpd_prev <= lpd_s;
      if (ready && dyn && (lpd_s != lpd_prev)) begin
        rc_cnt <= RECONNECT_LEN; // RQ13
      end else if (rc_cnt != 11'h000) begin
        rc_cnt <= rc_cnt - 11'h001;
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      o_self_powered <= 1'b0;
      o_full_speed_only <= 1'b0;
      o_eop_at_eof1 <= 1'b0;
      o_current_sense_ganged <= 1'b0;
      o_compound_device <= 1'b0;
      o_fixed_ports <= 2'h0;
      o_port_enable <= 2'h0;
      o_max_power_2ma <= 8'h00;
      o_hub_current_2ma <= 8'h00;
      o_power_on_time_2ms <= 8'h00;
      o_port_power_switch_out <= 1'b0;
      o_upstream_pullup_en <= 1'b0;
    end else begin
      o_self_powered <= next_self;
      o_full_speed_only <= cfg.cfg_byte1[CFG1_FS_ONLY_BIT]; // RQ5
      o_eop_at_eof1 <= i_full_speed_active && // RQ6
                       !cfg.cfg_byte1[CFG1_EOP_OFF_BIT];
      o_current_sense_ganged <= is_dflt ? lpd_s : // RQ7
                                cfg.cfg_byte1[CFG1_CUR_SENSE_BIT];
      o_compound_device <= is_dflt ? |fixed : // RQ8
                           cfg.cfg_byte2[CFG2_COMPOUND_BIT];
      o_fixed_ports <= {cfg.fixed_ports[PORT2_BIT],
                        cfg.fixed_ports[PORT1_BIT]}; // RQ9
      // disable masks are trusted to run downward from port 2
      o_port_enable <= {attach && !port_off[PORT2_BIT], // RQ12
                        attach && !port_off[PORT1_BIT]}; // RQ10 RQ11
      o_max_power_2ma <= next_self ? cfg.max_power_self : // RQ16
                         cfg.max_power_bus;
      o_hub_current_2ma <= next_self ? cfg.hub_current_self : // RQ16
                           cfg.hub_current_bus;
      o_power_on_time_2ms <= cfg.power_on_time; // RQ17
      o_port_power_switch_out <= pol ? attach : !attach; // RQ18 RQ13
      o_upstream_pullup_en <= attach && vbus_s; // RQ19
    end
  end

  // ==========================================================================
  // over-current persistence timer
  logic [17:0] oc_tick;
  logic [1:0] oc_steps;
  logic [1:0] oc_limit;

  assign oc_limit = cfg.cfg_byte2[CFG2_OC_TIMER_LSB +: 2];

  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst || !oc_s) begin
      oc_tick <= 18'h0_0000;
      oc_steps <= 2'h0;
      o_overcurrent_report <= 1'b0;
    end else if (oc_steps >= oc_limit) begin
      o_overcurrent_report <= 1'b1; // RQ15
    end else if (oc_tick == 18'(P_OC_STEP_CYC - 1)) begin
      oc_tick <= 18'h0_0000;
      oc_steps <= oc_steps + 2'h1; // RQ15
    end else begin
      oc_tick <= oc_tick + 18'h0_0001;
    end
  end

  assign o_cfg = cfg;
  assign o_config_done = ready;
  assign o_config_source = src;
  assign o_eeprom_error = ee_err;

endmodule

`default_nettype wire

// ==== hcl_pkg.sv ====
// package: constants, field layouts and carriers of the hub config loader
package hcl_pkg;

  // ==========================================================================
  // timing
  localparam int SYS_CLK_NS = 10;
  localparam int I2C_BIT_NS = 10000;
  localparam int I2C_QTR_CYC = (I2C_BIT_NS + 4 * SYS_CLK_NS - 1) /
                               (4 * SYS_CLK_NS);
  localparam logic [7:0] I2C_QTR_LAST = 8'(I2C_QTR_CYC - 1);
  localparam int OC_STEP_NS = 2000000;
  localparam int OC_STEP_CYC = OC_STEP_NS / SYS_CLK_NS;
  localparam int RECONNECT_NS = 20000;
  localparam logic [10:0] RECONNECT_LEN = 11'(RECONNECT_NS / SYS_CLK_NS);

  // ==========================================================================
  // eeprom access
  localparam logic [6:0] EE_SLAVE_ADDR = 7'h50;
  localparam logic [3:0] EE_FIRST_OFS = 4'h0;
  localparam logic [3:0] EE_LAST_OFS = 4'hF;
  localparam logic [3:0] BITN_ACK = 4'h8;

  // ==========================================================================
  // configuration source strap codes {hi, lo}; 2'h3 also selects eeprom
  localparam logic [1:0] SRC_DEFAULT = 2'h0;
  localparam logic [1:0] SRC_SMBUS = 2'h1;
  localparam logic [1:0] SRC_EEPROM = 2'h2;

  // ==========================================================================
  // eeprom byte offsets
  localparam int OFS_VENDOR_LO = 0;
  localparam int OFS_VENDOR_HI = 1;
  localparam int OFS_PRODUCT_LO = 2;
  localparam int OFS_PRODUCT_HI = 3;
  localparam int OFS_RELEASE_LO = 4;
  localparam int OFS_RELEASE_HI = 5;
  localparam int OFS_CFG1 = 6;
  localparam int OFS_CFG2 = 7;
  localparam int OFS_FIXED = 8;
  localparam int OFS_OFF_SELF = 9;
  localparam int OFS_OFF_BUS = 10;
  localparam int OFS_MAXP_SELF = 11;
  localparam int OFS_MAXP_BUS = 12;
  localparam int OFS_HC_SELF = 13;
  localparam int OFS_HC_BUS = 14;
  localparam int OFS_PON = 15;

  // ==========================================================================
  // field positions
  localparam int CFG1_POWER_MODE_BIT = 7;
  localparam int CFG1_FS_ONLY_BIT = 5;
  localparam int CFG1_EOP_OFF_BIT = 3;
  localparam int CFG1_CUR_SENSE_BIT = 1;
  localparam int CFG2_DYN_POWER_BIT = 7;
  localparam int CFG2_OC_TIMER_LSB = 4;
  localparam int CFG2_COMPOUND_BIT = 3;
  localparam int PORT1_BIT = 1;
  localparam int PORT2_BIT = 2;

  // ==========================================================================
  // built-in default values
  localparam logic [15:0] DEF_RELEASE = 16'h0000;
  localparam logic [7:0] DEF_CFG1_SELF = 8'h88;
  localparam logic [7:0] DEF_CFG2 = 8'h90;
  localparam logic [7:0] DEF_PORT_OFF = 8'h00;
  localparam logic [7:0] DEF_MAXP_SELF = 8'h01;
  localparam logic [7:0] DEF_MAXP_BUS = 8'h64;
  localparam logic [7:0] DEF_HC_SELF = 8'h01;
  localparam logic [7:0] DEF_HC_BUS = 8'h64;
  localparam logic [7:0] DEF_PON = 8'h32;

  // ==========================================================================
  // carriers
  typedef struct packed {
    logic [15:0] vendor_code;
    logic [15:0] product_code;
    logic [15:0] release_code;
    logic [7:0] cfg_byte1;
    logic [7:0] cfg_byte2;
    logic [7:0] fixed_ports;
    logic [7:0] port_off_self;
    logic [7:0] port_off_bus;
    logic [7:0] max_power_self;
    logic [7:0] max_power_bus;
    logic [7:0] hub_current_self;
    logic [7:0] hub_current_bus;
    logic [7:0] power_on_time;
  } hcl_cfg_s;

  typedef struct packed {
    logic scl_out;
    logic scl_oe;
    logic sda_out;
    logic sda_oe;
  } hcl_i2c_s;

  typedef enum logic [3:0] {
    ST_STRAP, ST_SMBUS_WAIT, ST_EE_START, ST_EE_DEVW, ST_EE_OFS,
    ST_EE_RESTART, ST_EE_DEVR, ST_EE_READ, ST_EE_STOP, ST_READY
  } hcl_state_e;

endpackage

// ==== hcl_config_loader_properties.sv ====
// checker: port properties of the hub config loader
`timescale 1ns/10ps
`default_nettype none
module hcl_config_loader_properties
  import hcl_pkg::*;
#(
  parameter int P_OC_STEP_CYC = 20,
  parameter int P_I2C_QTR_CYC = 250
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  // pins
  input wire logic i_local_power_detect,
  input wire logic i_power_polarity_strap,
  input wire logic i_upstream_bus_power_sense,
  input wire logic i_overcurrent,
  // results
  input wire hcl_i2c_s o_i2c,
  input wire hcl_cfg_s o_cfg,
  input wire logic o_config_done,
  input wire logic [1:0] o_config_source,
  input wire logic o_self_powered,
  input wire logic o_full_speed_only,
  input wire logic [1:0] o_port_enable,
  input wire logic o_overcurrent_report,
  input wire logic o_port_power_switch_out,
  input wire logic o_upstream_pullup_en
);
  // =====
  // helpers
  localparam int LO_MIN = P_I2C_QTR_CYC - 3;
  localparam int LO_MAX = 2 * P_I2C_QTR_CYC;
  int oc_cnt;
  always_ff @(posedge i_sys_clk) begin
    if (!i_overcurrent) oc_cnt <= 0;
    else oc_cnt <= oc_cnt + 1;
  end
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_nrst);
  sequence s_vbus_gone;
    !i_upstream_bus_power_sense [*4];
  endsequence
  sequence s_scl_low;
    o_i2c.scl_oe [*3] ##[LO_MIN:LO_MAX] $fell(o_i2c.scl_oe);
  endsequence
  // =====
  // properties
  a_pins_released: assert property (disable iff (1'b0)
    !i_nrst |=> !o_i2c.scl_oe && !o_i2c.sda_oe) else $error("pins driven");
  a_pullup_needs_vbus: assert property (
    s_vbus_gone |-> !o_upstream_pullup_en) else $error("pull-up w/o vbus");
  a_attach_after_load: assert property (
    o_upstream_pullup_en |-> o_config_done) else $error("early attach");
  a_self_port_off: assert property (
    o_config_done && o_self_powered |-> (o_port_enable &
    {o_cfg.port_off_self[2], o_cfg.port_off_self[1]}) == 2'b00)
    else $error("self-powered port enabled");
  a_bus_port_off: assert property (
    o_config_done && !o_self_powered |-> (o_port_enable &
    {o_cfg.port_off_bus[2], o_cfg.port_off_bus[1]}) == 2'b00)
    else $error("bus-powered port enabled");
  a_scl_low_time: assert property (
    $rose(o_i2c.scl_oe) |-> s_scl_low) else $error("scl low time");
  a_load_held: assert property (
    o_config_done |=> o_config_done && $stable(o_cfg) &&
    $stable(o_config_source)) else $error("config not held");
  a_fs_only_bit: assert property (
    o_config_done && $past(o_config_done) |->
    o_full_speed_only == $past(o_cfg.cfg_byte1[5])) else $error("fs only");
  a_dyn_self_mode: assert property (
    (o_cfg.cfg_byte2[7] && i_local_power_detect && o_upstream_pullup_en)
    [*8] |-> o_self_powered) else $error("dynamic mode not self");
  a_oc_delay: assert property (
    $rose(o_overcurrent_report) |->
    oc_cnt >= P_OC_STEP_CYC * o_cfg.cfg_byte2[5:4]) else $error("oc early");
  a_switch_polarity: assert property (
    o_upstream_pullup_en |-> o_port_power_switch_out ==
    i_power_polarity_strap) else $error("switch polarity");
endmodule
bind hcl_config_loader hcl_config_loader_properties
  #(.P_OC_STEP_CYC(P_OC_STEP_CYC), .P_I2C_QTR_CYC(P_I2C_QTR_CYC))
  i_props (.*);
`default_nettype wire

// ==== hcl_eeprom_model.sv ====
// partner: behavioural configuration eeprom on a pulled-up i2c bus
`timescale 1ns/10ps
`default_nettype none
module hcl_eeprom_model (
  // bus levels
  input wire logic i_scl,
  input wire logic i_sda,
  // fault control
  input wire logic i_nack,
  // data pull-down
  output logic o_sda_low
);
  logic [7:0] mem [16];
  logic [7:0] sh;
  logic [3:0] ptr;
  task automatic get_byte();
    for (int b = 0; b < 8; b++) begin
      @(posedge i_scl);
      sh = {sh[6:0], i_sda};
    end
  endtask
  task automatic ack();
    @(negedge i_scl);
    o_sda_low = 1'b1;
    @(negedge i_scl);
    o_sda_low = 1'b0;
  endtask
  task automatic read_out();
    logic more;
    more = 1'b1;
    while (more) begin
      sh = mem[ptr];
      ptr = ptr + 4'h1;
      for (int b = 0; b < 8; b++) begin
        o_sda_low = !sh[7-b];
        @(negedge i_scl);
      end
      o_sda_low = 1'b0;
      @(posedge i_scl);
      more = !i_sda;
      @(negedge i_scl);
    end
  endtask
  initial begin
    o_sda_low = 1'b0;
    forever begin
      @(negedge i_sda iff i_scl === 1'b1);
      get_byte();
      if (!i_nack && sh[7:1] == 7'h50) begin
        ack();
        if (!sh[0]) begin
          get_byte();
          ptr = sh[3:0];
          ack();
        end else begin
          read_out();
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== hcl_config_loader_test.sv ====
// testbench: hub config loader with straps, smbus and eeprom loads
`timescale 1ns/10ps
`default_nettype none
module hcl_config_loader_test;
  import hcl_pkg::*;
  localparam logic [15:0] VEND = 16'h5A3C; // arbitrary value
  localparam logic [15:0] PROD = 16'h0E71; // arbitrary value
  typedef struct packed {
    logic lpd;
    logic [1:0] fix;
    logic pol;
    logic [5:0] exp;
  } hcl_row_s;
  hcl_row_s rows [4] = '{'{1, 2'b00, 1, 6'b110001}, '{0, 2'b01, 0, 6'b001010},
    '{1, 2'b10, 0, 6'b111100}, '{0, 2'b11, 1, 6'b001111}};
  logic [7:0] ee [16] = '{8'h34, 8'h12, 8'h78, 8'h56, 8'h01, 8'h02, 8'hA0,
    8'h08, 8'h06, 8'h04, 8'h06, 8'h11, 8'h22, 8'h33, 8'h44, 8'h55};
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic s_hi = 1'b0;
  logic s_lo = 1'b0;
  logic lpd = 1'b1;
  logic pol = 1'b1;
  logic vbus = 1'b1;
  logic oc = 1'b0;
  logic fs = 1'b1;
  logic sm_valid = 1'b0;
  logic ee_nack = 1'b0;
  logic [1:0] fix = 2'b00;
  hcl_cfg_s sm_cfg = '0;
  hcl_cfg_s cfg;
  hcl_i2c_s i2c;
  logic done, ee_err, self_p, fso, eop, gang, comp, oc_rep, sw, pull, ee_low;
  logic [1:0] src, fixo, pen;
  logic [7:0] maxp, hcur, pon;
  wire scl = i2c.scl_oe ? 1'b0 : 1'b1;
  wire sda = (i2c.sda_oe || ee_low) ? 1'b0 : 1'b1;
  int n_mismatch = 0;
  int n_compared = 0;
  hcl_config_loader #(.P_OC_STEP_CYC(20), .P_DEFAULT_VENDOR(VEND),
    .P_DEFAULT_PRODUCT(PROD), .P_I2C_QTR_CYC(4)) i_dut (.i_sys_clk(clk),
    .i_nrst(nrst),
    .i_config_source_strap_hi(s_hi), .i_config_source_strap_lo(s_lo),
    .i_local_power_detect(lpd), .i_fixed_port_straps(fix),
    .i_power_polarity_strap(pol), .i_upstream_bus_power_sense(vbus),
    .i_overcurrent(oc), .i_full_speed_active(fs), .i_smbus_cfg(sm_cfg),
    .i_smbus_cfg_valid(sm_valid), .i_scl(scl), .i_sda(sda), .o_i2c(i2c),
    .o_cfg(cfg), .o_config_done(done), .o_config_source(src),
    .o_eeprom_error(ee_err), .o_self_powered(self_p),
    .o_full_speed_only(fso), .o_eop_at_eof1(eop),
    .o_current_sense_ganged(gang), .o_compound_device(comp),
    .o_fixed_ports(fixo), .o_port_enable(pen), .o_max_power_2ma(maxp),
    .o_hub_current_2ma(hcur), .o_power_on_time_2ms(pon),
    .o_overcurrent_report(oc_rep), .o_port_power_switch_out(sw),
    .o_upstream_pullup_en(pull));
  hcl_eeprom_model i_ee (.i_scl(scl), .i_sda(sda), .i_nack(ee_nack),
    .o_sda_low(ee_low));
  initial forever #5 clk = ~clk;
  // =====
  // tasks
  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen %0h want %0h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic start(input logic [1:0] code);
    nrst = 1'b0;
    sm_valid = 1'b0;
    {s_hi, s_lo} = code;
    cyc(10);
    check({i2c.scl_oe, i2c.sda_oe}, 2'b00);
    nrst = 1'b1;
  endtask
  task automatic wait_sig(input int lim, input bit use_pull);
    int k;
    k = 0;
    while (((use_pull ? pull : done) !== 1'b1) && k < lim) begin
      cyc(1);
      k++;
    end
    if (k >= lim) begin
      n_mismatch++;
      $display("MISMATCH t=%0t wait ran out", $time);
      stop_test();
    end
  endtask
  // =====
  // sequence
  initial begin
    foreach (rows[r]) begin
      lpd = rows[r].lpd;
      fix = rows[r].fix;
      pol = rows[r].pol;
      start(SRC_DEFAULT);
      wait_sig(20, 1'b1);
      cyc(1);
      check({self_p, gang, comp, fixo, sw}, rows[r].exp);
      check(cfg[127:80], {VEND, PROD, DEF_RELEASE});
      check(maxp, rows[r].lpd ? DEF_MAXP_SELF : DEF_MAXP_BUS);
      check({src, pen}, {SRC_DEFAULT, 2'b11});
    end
    vbus = 1'b0;
    cyc(5);
    check(pull, 1'b0);
    vbus = 1'b1;
    sm_cfg = '{16'h4D2A, 16'h0102, 16'h0310, 8'h02, 8'hA0, 8'h00, 8'h00,
      8'h04, 8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h0E};
    lpd = 1'b1;
    start(SRC_SMBUS);
    cyc(2);
    sm_valid = 1'b1;
    wait_sig(20, 1'b1);
    cyc(1);
    check(cfg, sm_cfg);
    check({self_p, gang, maxp, hcur, pon, pen, eop},
      {2'b11, 8'h0A, 8'h0C, 8'h0E, 2'b11, 1'b1});
    sm_cfg.vendor_code = 16'h0000;
    fs = 1'b0;
    cyc(3);
    check({eop, cfg.vendor_code}, {1'b0, 16'h4D2A});
    fs = 1'b1;
    oc = 1'b1;
    cyc(30);
    check(oc_rep, 1'b0);
    cyc(20);
    check(oc_rep, 1'b1);
    oc = 1'b0;
    lpd = 1'b0;
    cyc(6);
    check({pull, pen}, 3'b000);
    wait_sig(2500, 1'b1);
    cyc(1);
    check({self_p, maxp, hcur, pen}, {1'b0, 8'h0B, 8'h0D, 2'b01});
    foreach (ee[k]) i_ee.mem[k] = ee[k];
    lpd = 1'b1;
    start(SRC_EEPROM);
    cyc(90);
    ee_nack = 1'b1;
    start(2'b11);
    wait_sig(2000, 1'b0);
    cyc(2);
    check({src, ee_err, cfg.vendor_code}, {2'b00, 1'b1, VEND});
    ee_nack = 1'b0;
    start(SRC_EEPROM);
    cyc(99);
    check({pull, done}, 2'b00);
    wait_sig(9000, 1'b0);
    cyc(3);
    check(cfg, {ee[1], ee[0], ee[3], ee[2], ee[5], ee[4], ee[6], ee[7],
      ee[8], ee[9], ee[10], ee[11], ee[12], ee[13], ee[14], ee[15]});
    check({src, ee_err, self_p, fso, comp, fixo, pen, maxp, pon},
      {5'b10011, 5'b11101, 8'h11, 8'h55});
    stop_test();
  end
endmodule
`default_nettype wire
